// *** rtl/srx_pkg.sv ***
// Shared constants, types and helpers of the serial receiver control block
package srx_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_IRQ_EN = 10'h01f;
   localparam logic [9:0] IDX_IRQ_ST = 10'h023;
   localparam logic [9:0] IDX_LANE_PD = 10'h201;
   localparam logic [9:0] IDX_CDR_RST = 10'h206;
   localparam logic [9:0] IDX_CDR_CFG = 10'h230;
   localparam logic [9:0] IDX_EQ_CFG = 10'h268;
   localparam logic [9:0] IDX_SYN_CTL = 10'h280;
   localparam logic [9:0] IDX_SYN_ST = 10'h281;
   localparam logic [9:0] IDX_REF_DIV = 10'h289;
   localparam logic [9:0] IDX_LINK_CFG = 10'h2f0;
   localparam logic [9:0] IDX_LANE_ST = 10'h2f1;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTL_EN_BIT = 0;
   localparam int CTL_RECAL_BIT = 2;
   localparam int ST_LOCK_BIT = 0;
   localparam int ST_CAL_BIT = 3;
   localparam int ST_BHI_BIT = 4;
   localparam int ST_BLO_BIT = 5;
   localparam int IRQ_LOCK_BIT = 2;
   localparam int IRQ_LOST_BIT = 3;
   localparam int CDR_HALF_BIT = 5;
   localparam int CDR_OVS_BIT = 1;
   localparam int CDR_RST_BIT = 0;
   localparam int EQ_LSB = 6;
   localparam int DIV_LSB = 0;
   localparam int LK_DUAL_BIT = 2;
   localparam int LK_NLANE_LSB = 4;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_LINK_CFG = 8'h80;
   localparam logic [7:0] IRQ_PLL_MASK = 8'h0c;

   // ----------------------------------------------------------------
   // Control characters and sync figures
   // ----------------------------------------------------------------
   localparam logic [7:0] K_COMMA = 8'hbc;
   localparam logic [7:0] K_ALIGN = 8'h7c;
   localparam logic [7:0] K_ILAS = 8'h1c;
   localparam logic [2:0] CGS_COUNT = 3'h4;

   typedef enum logic [2:0] {
      LK_OFF = 3'b000,
      LK_CGS = 3'b001,
      LK_SYNCED = 3'b010,
      LK_ILAS = 3'b011,
      LK_DATA = 3'b100
   } srx_link_e;

   // Lanes fill in ascending order; link 1 starts after link 0's lanes
   function automatic logic srx_lane_in_link(input int lane,
      input logic link, input logic dual, input logic [3:0] n);
      int lo;
      lo = (dual && link) ? int'(n) : 0;
      return !(link && !dual) && lane >= lo && lane < lo + int'(n);
   endfunction : srx_lane_in_link

endpackage : srx_pkg

// *** rtl/srx_cgs.sv ***
// Code-group synchronisation tracker for one lane
`timescale 1ns/1ps
`default_nettype none
module srx_cgs
   import srx_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic lane_enable,
   input wire logic sym_valid,
   input wire logic [7:0] sym_data,
   input wire logic sym_ctrl,
   input wire logic sym_err,
   output logic cgs_done
);
   logic [2:0] cnt_r;
   logic done_r;
   wire comma = sym_ctrl & (sym_data == K_COMMA);

   // Count consecutive commas; a code error drops sync at once
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_r <= 3'h0;
         done_r <= 1'b0;
      end
      else if (!lane_enable)
      begin
         cnt_r <= 3'h0;
         done_r <= 1'b0;
      end
      else if (sym_valid)
      begin
         if (sym_err)
         begin
            cnt_r <= 3'h0;
            done_r <= 1'b0;
         end
         else if (comma)
         begin
            if (cnt_r != CGS_COUNT)
               cnt_r <= cnt_r + 3'h1;
            if (cnt_r == CGS_COUNT - 3'h1)
               done_r <= 1'b1;
         end
         else if (!done_r)
            cnt_r <= 3'h0;
      end
   end

   assign cgs_done = done_r;
endmodule : srx_cgs
`default_nettype wire

// *** rtl/srx_deskew.sv ***
// Elastic buffer of one lane, filled from the alignment point
`timescale 1ns/1ps
`default_nettype none
module srx_deskew
   import srx_pkg::*;
#(
   parameter int DEPTH = 8
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic arm,
   input wire logic release_all,
   input wire logic sym_valid,
   input wire logic [7:0] sym_data,
   input wire logic sym_ctrl,
   output logic arrived,
   output logic out_valid,
   output logic [7:0] out_data,
   output logic out_ctrl,
   output logic overflow
);
   localparam int AW = $clog2(DEPTH);
   logic [8:0] mem [DEPTH];
   logic [AW-1:0] wptr_r, rptr_r;
   logic [AW:0] fill_r;
   logic prev_a_r, arrived_r, ovf_r, ov_r, oc_r;
   logic [7:0] od_r;

   // Alignment point is an /A/ followed directly by /R/
   wire is_r = sym_valid & sym_ctrl & (sym_data == K_ILAS);
   wire hit = arm & ~arrived_r & prev_a_r & is_r;
   wire full = fill_r == (AW+1)'(DEPTH);
   wire wr = sym_valid & (hit | arrived_r) & ~full;
   wire rd = release_all & (fill_r != '0);

   // Storage needs no reset; pointers gate what is read
   always_ff @(posedge hclk)
   begin
      if (wr)
         mem[wptr_r] <= {sym_ctrl, sym_data};
   end

   // Early lanes hold here until the whole link is released
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {prev_a_r, arrived_r, ovf_r, ov_r, oc_r} <= 5'h00;
         wptr_r <= '0;
         rptr_r <= '0;
         fill_r <= '0;
         od_r <= 8'h00;
      end
      else if (!arm)
      begin
         {prev_a_r, arrived_r, ovf_r, ov_r} <= 4'h0;
         wptr_r <= '0;
         rptr_r <= '0;
         fill_r <= '0;
      end
      else
      begin
         if (sym_valid)
            prev_a_r <= sym_ctrl & (sym_data == K_ALIGN);
         if (hit)
            arrived_r <= 1'b1;
         if (wr)
            wptr_r <= wptr_r + 1'b1;
         if (rd)
            rptr_r <= rptr_r + 1'b1;
         fill_r <= fill_r + (AW+1)'(wr) - (AW+1)'(rd);
         if (sym_valid & arrived_r & full)
            ovf_r <= 1'b1; // Lane arrived too early to absorb
         ov_r <= rd;
         if (rd)
            {oc_r, od_r} <= mem[rptr_r];
      end
   end

   assign arrived = arrived_r;
   assign overflow = ovf_r;
   assign out_valid = ov_r;
   assign out_data = od_r;
   assign out_ctrl = oc_r;
endmodule : srx_deskew
`default_nettype wire

// *** rtl/srx_top.sv ***
// Serial receiver setup registers and link synchronisation control
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module srx_top
   import srx_pkg::*;
#(
   parameter int LANES = 8,
   parameter int BUF_DEPTH = 8,
   parameter int LMFC_CYCLES = 8
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic pll_locked,
   input wire logic pll_cal_done,
   input wire logic pll_band_hi,
   input wire logic pll_band_lo,
   output logic pll_enable,
   output logic pll_recal,
   output logic [1:0] ref_divider_select,
   output logic half_rate_sampling_on,
   output logic double_oversample_on,
   output logic cdr_reset,
   output logic [7:0] lane_off_mask,
   output logic [1:0] equalizer_power_select,
   output logic pll_irq,
   input wire logic [LANES-1:0] lane_valid,
   input wire logic [LANES*8-1:0] lane_data,
   input wire logic [LANES-1:0] lane_ctrl,
   input wire logic [LANES-1:0] lane_err,
   output logic link0_sync_request_n,
   output logic link1_sync_request_n,
   output logic [LANES-1:0] aligned_valid,
   output logic [LANES*8-1:0] aligned_data,
   output logic [LANES-1:0] aligned_ctrl
);

   // ----------------------------------------------------------------
   // Synthesizer status inputs
   // ----------------------------------------------------------------
   logic [3:0] ps1_r, ps2_r, ps3_r, pst_r;
   wire [3:0] pll_pins = {pll_band_lo, pll_band_hi, pll_cal_done,
      pll_locked};

   // Analog flags are asynchronous; accept once stages two and three agree
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ps1_r <= 4'h0;
         ps2_r <= 4'h0;
         ps3_r <= 4'h0;
         pst_r <= 4'h0;
      end
      else
      begin
         ps1_r <= pll_pins;
         ps2_r <= ps1_r;
         ps3_r <= ps2_r;
         pst_r <= (ps2_r == ps3_r) ? ps3_r : pst_r;
      end
   end

   wire lock_f = pst_r[0];
   // Live view; reading has no side effect on it
   wire [7:0] syn_st_w = {2'b00, pst_r[3], pst_r[2], pst_r[1], 2'b00,
      lock_f};

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------
   logic ph_read_r, ph_write_r, rd_done_r;
   logic [9:0] ph_idx_r;
   logic [31:0] hrdata_r;
   wire addr_ok = hsel & hready & htrans[1];

   // Address phase capture; reads take one wait state for a flopped answer
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_read_r <= 1'b0;
         ph_write_r <= 1'b0;
         ph_idx_r <= 10'h000;
         rd_done_r <= 1'b0;
      end
      else
      begin
         if (hready)
         begin
            ph_read_r <= addr_ok & ~hwrite;
            ph_write_r <= addr_ok & hwrite;
            ph_idx_r <= haddr[11:2];
         end
         rd_done_r <= ph_read_r & ~rd_done_r;
      end
   end

   assign hreadyout = ~(ph_read_r & ~rd_done_r);
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   function automatic logic wr_hit(input logic [9:0] idx);
      return ph_write_r && ph_idx_r == idx;
   endfunction : wr_hit

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [7:0] irq_en_r, irq_st_r, lane_pd_r, cdr_rst_r, cdr_cfg_r;
   logic [7:0] eq_cfg_r, syn_ctl_r, ref_div_r, link_cfg_r;
   logic lock_prev_r;
   logic [LANES-1:0] cgs_done;

   // Plain read/write registers steering the lanes and synthesizer
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_en_r <= RST_ZERO;
         lane_pd_r <= RST_ZERO;
         cdr_rst_r <= RST_ZERO;
         cdr_cfg_r <= RST_ZERO;
         eq_cfg_r <= RST_ZERO;
         syn_ctl_r <= RST_ZERO;
         ref_div_r <= RST_ZERO;
         link_cfg_r <= RST_LINK_CFG;
      end
      else
      begin
         if (wr_hit(IDX_IRQ_EN)) irq_en_r <= hwdata[7:0];
         if (wr_hit(IDX_LANE_PD)) lane_pd_r <= hwdata[7:0];
         if (wr_hit(IDX_CDR_RST)) cdr_rst_r <= hwdata[7:0];
         if (wr_hit(IDX_CDR_CFG)) cdr_cfg_r <= hwdata[7:0];
         if (wr_hit(IDX_EQ_CFG)) eq_cfg_r <= hwdata[7:0];
         if (wr_hit(IDX_SYN_CTL)) syn_ctl_r <= hwdata[7:0];
         if (wr_hit(IDX_REF_DIV)) ref_div_r <= hwdata[7:0];
         if (wr_hit(IDX_LINK_CFG)) link_cfg_r <= hwdata[7:0];
      end
   end

   // Lock/lost events; a new event wins over a same-cycle clear
   wire ev_lock = lock_f & ~lock_prev_r;
   wire ev_lost = ~lock_f & lock_prev_r;
   wire [7:0] irq_set = {4'h0, ev_lost, ev_lock, 2'b00} & irq_en_r;
   wire [7:0] irq_clr = wr_hit(IDX_IRQ_ST) ? hwdata[7:0] & IRQ_PLL_MASK
      : 8'h00;
   wire [7:0] irq_st_nxt = (irq_st_r & ~irq_clr) | irq_set;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_st_r <= RST_ZERO;
         lock_prev_r <= 1'b0;
      end
      else
      begin
         irq_st_r <= irq_st_nxt;
         lock_prev_r <= lock_f;
      end
   end

   // Read selection, unmapped addresses read as zero
   wire [7:0] rd_mux =
      (ph_idx_r == IDX_IRQ_EN) ? irq_en_r :
      (ph_idx_r == IDX_IRQ_ST) ? irq_st_r :
      (ph_idx_r == IDX_LANE_PD) ? lane_pd_r :
      (ph_idx_r == IDX_CDR_RST) ? cdr_rst_r :
      (ph_idx_r == IDX_CDR_CFG) ? cdr_cfg_r :
      (ph_idx_r == IDX_EQ_CFG) ? eq_cfg_r :
      (ph_idx_r == IDX_SYN_CTL) ? syn_ctl_r :
      (ph_idx_r == IDX_SYN_ST) ? syn_st_w :
      (ph_idx_r == IDX_REF_DIV) ? ref_div_r :
      (ph_idx_r == IDX_LINK_CFG) ? link_cfg_r :
      (ph_idx_r == IDX_LANE_ST) ? 8'(cgs_done) : 8'h00;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_r <= 32'h0000_0000;
      else if (ph_read_r & ~rd_done_r)
         hrdata_r <= {24'h00_0000, rd_mux};
   end

   // Register fields driven straight to the analog and lane controls
   assign pll_enable = syn_ctl_r[CTL_EN_BIT];
   assign pll_recal = syn_ctl_r[CTL_RECAL_BIT];
   assign ref_divider_select = ref_div_r[DIV_LSB +: 2];
   assign half_rate_sampling_on = cdr_cfg_r[CDR_HALF_BIT];
   assign double_oversample_on = cdr_cfg_r[CDR_OVS_BIT];
   assign cdr_reset = cdr_rst_r[CDR_RST_BIT];
   assign lane_off_mask = lane_pd_r;
   assign equalizer_power_select = eq_cfg_r[EQ_LSB +: 2];
   assign pll_irq = |(irq_st_r & irq_en_r & IRQ_PLL_MASK);

   // ----------------------------------------------------------------
   // Multiframe clock enable
   // ----------------------------------------------------------------
   logic [7:0] lmfc_cnt_r;
   wire lmfc_edge = lmfc_cnt_r == 8'h00;

   // Free-running divider; its wrap is the local multiframe edge
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         lmfc_cnt_r <= 8'h00;
      else if (lmfc_cnt_r == 8'(LMFC_CYCLES - 1))
         lmfc_cnt_r <= 8'h00;
      else
         lmfc_cnt_r <= lmfc_cnt_r + 8'h01;
   end

   // ----------------------------------------------------------------
   // Lanes: comma tracking and deskew buffers
   // ----------------------------------------------------------------
   srx_link_e st_r [2];
   srx_link_e st_nxt [2];
   wire dual = link_cfg_r[LK_DUAL_BIT];
   wire [3:0] nlane = link_cfg_r[LK_NLANE_LSB +: 4];
   logic [LANES-1:0] mem0, mem1, arrived, ovf;

   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : g_lane
         // Membership fills lanes from zero upward
         assign mem0[g] = srx_lane_in_link(g, 1'b0, dual, nlane);
         assign mem1[g] = srx_lane_in_link(g, 1'b1, dual, nlane);
         wire lk = mem1[g];
         wire on = (mem0[g] | mem1[g]) & ~lane_pd_r[g];
         wire arm = on & (st_r[lk] == LK_ILAS || st_r[lk] == LK_DATA);

         srx_cgs u_cgs (
            .hclk(hclk),
            .hresetn(hresetn),
            .lane_enable(on),
            .sym_valid(lane_valid[g]),
            .sym_data(lane_data[g*8 +: 8]),
            .sym_ctrl(lane_ctrl[g]),
            .sym_err(lane_err[g]),
            .cgs_done(cgs_done[g])
         );

         srx_deskew #(.DEPTH(BUF_DEPTH)) u_dsk (
            .hclk(hclk),
            .hresetn(hresetn),
            .arm(arm),
            .release_all(st_r[lk] == LK_DATA),
            .sym_valid(lane_valid[g]),
            .sym_data(lane_data[g*8 +: 8]),
            .sym_ctrl(lane_ctrl[g]),
            .arrived(arrived[g]),
            .out_valid(aligned_valid[g]),
            .out_data(aligned_data[g*8 +: 8]),
            .out_ctrl(aligned_ctrl[g]),
            .overflow(ovf[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Per-link synchronisation state
   // ----------------------------------------------------------------
   wire [1:0] link_en = {dual & link_cfg_r[1], link_cfg_r[0]};
   wire [LANES-1:0] m0 = mem0 & ~lane_pd_r;
   wire [LANES-1:0] m1 = mem1 & ~lane_pd_r;
   wire [1:0] all_cgs = {&(cgs_done | ~m1), &(cgs_done | ~m0)};
   wire [1:0] lost = {|(m1 & (~cgs_done | ovf)), |(m0 & (~cgs_done | ovf))};
   wire [1:0] all_arr = {&(arrived | ~m1), &(arrived | ~m0)};
   logic [1:0] sync_r;

   always_comb
   begin
      for (int k = 0; k < 2; k++)
      begin
         st_nxt[k] = st_r[k];
         case (st_r[k])
            LK_OFF: st_nxt[k] = LK_CGS;
            LK_CGS: if (all_cgs[k]) st_nxt[k] = LK_SYNCED;
            LK_SYNCED:
               if (lost[k]) st_nxt[k] = LK_CGS;
               else if (lmfc_edge) st_nxt[k] = LK_ILAS;
            LK_ILAS:
               if (lost[k]) st_nxt[k] = LK_CGS;
               else if (all_arr[k]) st_nxt[k] = LK_DATA;
            LK_DATA: if (lost[k]) st_nxt[k] = LK_CGS;
            default: st_nxt[k] = LK_OFF;
         endcase
         if (!link_en[k])
            st_nxt[k] = LK_OFF;
      end
   end

   // Sync line is high only in ILAS and DATA, from the multiframe edge after code-group sync
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_r[0] <= LK_OFF;
         st_r[1] <= LK_OFF;
         sync_r <= 2'b00;
      end
      else
      begin
         for (int k = 0; k < 2; k++)
         begin
            st_r[k] <= st_nxt[k];
            sync_r[k] <= st_nxt[k] == LK_ILAS || st_nxt[k] == LK_DATA;
         end
      end
   end

   assign link0_sync_request_n = sync_r[0];
   assign link1_sync_request_n = sync_r[1];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_lock_live: assert property (pll_locked [*5] |-> syn_st_w[0])
      else $error("lock status not shown");
   a_cal_live: assert property (pll_cal_done [*5] |-> syn_st_w[3])
      else $error("calibration status not shown");
   a_irq_lock_set: assert property ($rose(lock_f) && irq_en_r[2]
      |=> irq_st_r[2] && pll_irq) else $error("lock event lost");
   a_eq_write: assert property (wr_hit(IDX_EQ_CFG)
      |=> equalizer_power_select == $past(hwdata[7:6]))
      else $error("equalizer mode not applied");
   a_pd_write: assert property (wr_hit(IDX_LANE_PD)
      |=> lane_off_mask == $past(hwdata[7:0]))
      else $error("lane power-down not applied");
   a_sync_lmfc: assert property ($rose(link0_sync_request_n)
      |-> $past(lmfc_edge) && $past(all_cgs[0]))
      else $error("sync released off multiframe edge");
   a_sync_held: assert property (st_r[0] == LK_CGS
      |-> !link0_sync_request_n) else $error("sync high before sync");
   a_lost_resync: assert property (st_r[0] == LK_DATA && lost[0]
      |=> !link0_sync_request_n [*2]) else $error("no resync request");
   a_release_all: assert property ($rose(aligned_valid[0]) && m0[0]
      |-> $past(all_arr[0], 2)) else $error("lane released early");
   a_read_wait: assert property (ph_read_r && !rd_done_r
      |-> !hreadyout ##1 hreadyout) else $error("read wait wrong");

   c_link_data: cover property (st_r[0] == LK_ILAS ##1 st_r[0] == LK_DATA);
   c_irq_lock: cover property ($rose(irq_st_r[2]));
   c_resync: cover property (st_r[0] == LK_DATA ##1 st_r[0] == LK_CGS);
   c_read: cover property (ph_read_r ##2 hreadyout);

endmodule : srx_top
`default_nettype wire

// *** testbench/srx_tx_model.sv ***
// Behavioural lane transmitter standing on the far side of link 0
`timescale 1ns/1ps
`default_nettype none
module srx_tx_model
   import srx_pkg::*;
#(
   parameter int LANES = 8
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sync_n,
   input wire logic bad,
   output logic [LANES-1:0] lane_valid,
   output logic [LANES*8-1:0] lane_data,
   output logic [LANES-1:0] lane_ctrl,
   output logic [LANES-1:0] lane_err
);
   int k;
   // Symbol j after the release: commas, then A, R, count
   function automatic logic [8:0] sym(input int j);
      if (j < 0)
         return {1'b1, K_COMMA};
      if (j < 2)
         return {1'b1, j == 0 ? K_ALIGN : K_ILAS};
      return {1'b0, 8'(j)};
   endfunction : sym
   // Any sync request throws the lanes back to commas
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         k <= -2;
      else
         k <= sync_n ? k + 1 : -2;
   end
   // Odd lanes lag one cycle so the receiver must deskew
   always_comb
   begin
      for (int g = 0; g < LANES; g++)
      begin
         lane_valid[g] = hresetn;
         lane_err[g] = bad;
         {lane_ctrl[g], lane_data[g*8 +: 8]} = sym(k - g % 2);
      end
   end
endmodule : srx_tx_model
`default_nettype wire

// *** testbench/testbench.sv ***
// Register and link bring-up tests of the receiver control block
`timescale 1ns/1ps
`default_nettype none
module testbench
   import srx_pkg::*;
;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, bad = 0;
   logic [11:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = '0, hrdata, r;
   logic hreadyout, hresp, pll_enable, pll_recal, pll_irq, cdr_reset;
   logic half_rate_sampling_on, double_oversample_on;
   logic link0_sync_request_n, link1_sync_request_n;
   logic pll_locked = 0, pll_cal_done = 0, pll_band_hi = 0, pll_band_lo = 0;
   logic [1:0] ref_divider_select, equalizer_power_select;
   logic [7:0] lane_off_mask, lane_valid, lane_ctrl, lane_err;
   logic [7:0] aligned_valid, aligned_ctrl;
   logic [63:0] lane_data, aligned_data;
   int error_cnt = 0, checked = 0, n;
   logic [9:0] ia [6] = '{IDX_REF_DIV, IDX_CDR_CFG, IDX_CDR_RST,
      IDX_LANE_PD, IDX_EQ_CFG, IDX_SYN_CTL};
   logic [7:0] va [6] = '{8'h02, 8'h02, 8'h01, 8'hf0, 8'h40, 8'h05};

   always #5 hclk = ~hclk;

   srx_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pll_locked,
      .pll_cal_done, .pll_band_hi, .pll_band_lo, .pll_enable, .pll_recal,
      .ref_divider_select, .half_rate_sampling_on, .double_oversample_on,
      .cdr_reset, .lane_off_mask, .equalizer_power_select, .pll_irq,
      .lane_valid, .lane_data, .lane_ctrl, .lane_err, .link0_sync_request_n,
      .link1_sync_request_n, .aligned_valid, .aligned_data, .aligned_ctrl);

   srx_tx_model tx (.hclk, .hresetn, .sync_n(link0_sync_request_n), .bad,
      .lane_valid, .lane_data, .lane_ctrl, .lane_err);

   // ---------------------------------------------
   // Bus master and checking
   // ---------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   // Sample at the falling edge, clear of the rising-edge updates
   task automatic tick();
      @(negedge hclk);
      n++;
      if (n > 300)
      begin
         chk(0, 1);
         give_verdict();
      end
   endtask : tick

   // One single word transfer; entered just after a rising edge
   task automatic xfer(input logic w, input logic [9:0] i,
      input logic [7:0] d);
      hsel <= 1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {i, 2'b00};
      n = 0;
      do tick(); while (!hreadyout);
      @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      n = 0;
      do tick(); while (!hreadyout);
      r = hrdata;
      @(posedge hclk);
   endtask : xfer

   task automatic rdc(input logic [9:0] i, input logic [7:0] e);
      xfer(0, i, 8'h00);
      chk(r, {24'h0, e});
   endtask : rdc

   // ---------------------------------------------
   // Test sequence
   // ---------------------------------------------
   initial
   begin
      repeat (5) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      chk(link0_sync_request_n, 0);
      for (int i = 0; i < 6; i++)
         xfer(1, ia[i], va[i]);
      for (int i = 0; i < 6; i++)
         rdc(ia[i], va[i]);
      chk({hresp, ref_divider_select, pll_enable, pll_recal,
         half_rate_sampling_on, double_oversample_on, cdr_reset,
         lane_off_mask, equalizer_power_select},
         {1'b0, 2'h2, 5'b11011, 8'hf0, 2'h1});
      xfer(1, IDX_CDR_RST, 8'h00);
      rdc(IDX_CDR_RST, 8'h00);
      chk(cdr_reset, 0);
      xfer(1, 10'h284, 8'h62);
      rdc(10'h284, 8'h00);
      $display("test registers done");
      xfer(1, IDX_IRQ_EN, IRQ_PLL_MASK);
      pll_locked <= 1;
      pll_cal_done <= 1;
      pll_band_hi <= 1;
      pll_band_lo <= 1;
      repeat (10) @(posedge hclk);
      rdc(IDX_SYN_ST, 8'h39);
      xfer(1, IDX_SYN_ST, 8'h00);
      rdc(IDX_SYN_ST, 8'h39);
      xfer(1, IDX_SYN_CTL, 8'h01);
      rdc(IDX_SYN_CTL, 8'h01);
      chk(pll_recal, 0);
      xfer(1, IDX_SYN_CTL, 8'h05);
      rdc(IDX_SYN_CTL, 8'h05);
      chk(pll_recal, 1);
      rdc(IDX_IRQ_ST, 8'h04);
      chk(pll_irq, 1);
      xfer(1, IDX_IRQ_ST, 8'h04);
      rdc(IDX_IRQ_ST, 8'h00);
      chk(pll_irq, 0);
      pll_locked <= 0;
      repeat (10) @(posedge hclk);
      rdc(IDX_IRQ_ST, 8'h08);
      chk(pll_irq, 1);
      xfer(1, IDX_IRQ_EN, 8'h00);
      rdc(IDX_IRQ_EN, 8'h00);
      chk(pll_irq, 0);
      rdc(IDX_LANE_ST, 8'h0f);
      $display("test status done");
      xfer(1, IDX_LINK_CFG, 8'h81);
      n = 0;
      while (link0_sync_request_n !== 1)
         tick();
      chk(n > 0 && n <= 12, 1);
      chk(link1_sync_request_n, 0);
      n = 0;
      while (aligned_valid === 8'h00)
         tick();
      chk({aligned_valid, aligned_ctrl}, 16'h0f0f);
      chk(aligned_data, {32'h0, {4{K_ILAS}}});
      tick();
      chk(aligned_data, {32'h0, {4{8'h02}}});
      @(posedge hclk);
      bad <= 1;
      @(posedge hclk);
      bad <= 0;
      n = 0;
      while (link0_sync_request_n !== 0)
         tick();
      chk(n <= 2, 1);
      $display("test link done");
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
